//--- ttc_pkg.sv
// Constants, types and rule notes for the teletype channel controller
// Notes on behaviour
// - Status store: enable and alarm per port
// - Alarm bit reflects its own port trouble
// - Send to any enabled port combination
// - No receive arbitration; collisions garble character
// - Demand mode: interrupt after final character bit
// - Host polls; device returns character or status
// - Host message: 15 bits then 15 zeros
// - Frame: start, 8 bits LSB first, 2 stops
// - All eight bits reach host and terminals
// - Eleven-bit character lasts 100 milliseconds
// - Channel and line sequencer state sets
// - Character uses normal code; status maintenance code
// - Load first 15 bits; count trailing zeros
// - Process state: classify message, check odd parity
// - Forward to line buffer only for characters
// - One-hot return code: parity, busy, accepted
// - Rest plus character: transmit to enabled ports
// - Sent character copied back for later poll
// - Hit for quarter bit, then rest or receive
// - Received character to line register, flag set
// - Poll returns line register with parity
// - Shift into cleared buffer until lowest one
// - Decision table for control and character messages
// - Control message writes enables and alarm test
`default_nettype none

package ttc_pkg;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Timing
   localparam int CLK_HZ      = 50_000_000;
   localparam int CHAR_MS     = 100;
   localparam int FRAME_BITS  = 11;
   localparam int QTR_PER_BIT = 4;
   // Longest quarter bit, rounded down
   localparam int QTR_CYC     =
      (CLK_HZ / 1000) * CHAR_MS / (FRAME_BITS * QTR_PER_BIT);
   localparam logic [5:0] FRAME_QTRS = 6'(FRAME_BITS * QTR_PER_BIT);
   localparam logic [5:0] FIRST_SAMPLE = 6'h06;
   localparam logic [5:0] LAST_SAMPLE  = 6'h22;

   // ==========================================================
   // Host message layout
   localparam int MSG_W   = 15;
   localparam int PAR_BIT = 3;
   localparam int DAT_LSB = 4;
   localparam int RC_LSB  = 12;
   localparam logic [2:0] SC_NORMAL = 3'h1;
   localparam logic [2:0] SC_MAINT  = 3'h3;
   localparam logic [2:0] RC_BADPAR = 3'h1;
   localparam logic [2:0] RC_BUSY   = 3'h2;
   localparam logic [2:0] RC_ACCEPT = 3'h4;
   localparam logic [3:0] REPLY_LAST = 4'hE;

   // ==========================================================
   // Registers
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STAT = 4'h4;
   localparam logic [3:0] OFS_LINE = 4'h8;
   localparam int CTRL_DEMAND_BIT = 0;
   localparam logic CTRL_DEMAND_RST = 1'b1;
   localparam logic [10:0] SYNC_RST = 11'h20F;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      CH_RECV = 3'b001,
      CH_PROC = 3'b010,
      CH_XMIT = 3'b100
   } ttc_chan_t;

   typedef enum logic [3:0] {
      LN_REST = 4'b0001,
      LN_XMIT = 4'b0010,
      LN_HIT  = 4'b0100,
      LN_RECV = 4'b1000
   } ttc_line_t;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
   } ttc_ahb_req_t;

   typedef struct packed {
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
   } ttc_ahb_rsp_t;

endpackage : ttc_pkg

`default_nettype wire

//--- ttc_top.sv
// Teletype channel controller: host link, line sequencer and bus slave
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`default_nettype none

module ttc_top #(
   parameter int QTR_CYC = ttc_pkg::QTR_CYC
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   input  wire ttc_pkg::ttc_ahb_req_t ahb_i,
   input  wire logic                  hready,
   output var  ttc_pkg::ttc_ahb_rsp_t ahb_o,
   input  wire logic                  host_rx_data,
   input  wire logic                  host_shift_n,
   input  wire logic                  host_init,
   output logic                       host_tx_data,
   output logic                       host_tx_en,
   output logic                       demand_irq,
   input  wire logic [3:0]            tty_rx,
   input  wire logic [3:0]            tty_alarm,
   output logic [3:0]                 tty_tx
);
   timeunit 1ns;
   timeprecision 1ps;

   localparam int QW = $clog2(QTR_CYC);

   if (QTR_CYC < 2) begin : g_chk
      $error("QTR_CYC must be at least 2");
   end

   // ==========================================================
   // Reply builder: odd parity over data plus parity bit
   function automatic logic [14:0] build_reply(
      input logic [2:0] sc,
      input logic [7:0] dat,
      input logic [2:0] rc
   );
      build_reply = {rc, dat, ~^dat, sc};
   endfunction : build_reply

   // ==========================================================
   // Input synchronisers
   logic [10:0] sy1_ff;
   logic [10:0] sy2_ff;
   logic [1:0]  edge_ff;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sy1_ff  <= ttc_pkg::SYNC_RST;
         sy2_ff  <= ttc_pkg::SYNC_RST;
         edge_ff <= 2'h1;
      end else if (ce) begin
         sy1_ff  <= {host_init, host_shift_n, host_rx_data,
                     tty_alarm, tty_rx};
         sy2_ff  <= sy1_ff;
         edge_ff <= sy2_ff[10:9];
      end
   end

   logic [3:0] rx_s;
   logic [3:0] alm_s;
   logic       dat_s;
   logic       shift_p;
   logic       init_p;
   logic       line_in;

   assign rx_s    = sy2_ff[3:0];
   assign alm_s   = sy2_ff[7:4];
   assign dat_s   = sy2_ff[8];
   // Low-to-high edge of the shift strobe clocks one bit
   assign shift_p = sy2_ff[9] & ~edge_ff[0];
   assign init_p  = sy2_ff[10] & ~edge_ff[1];
   // Space on any port dominates; collisions simply garble
   assign line_in = &rx_s;

   // ==========================================================
   // Control register and line status store
   logic       demand_ff;
   logic [3:0] enable_ff;
   logic [3:0] test_ff;
   logic [3:0] alarm;
   logic       rdy_ff;
   logic [7:0] line_reg_ff;

   assign alarm = alm_s | test_ff;

   // ==========================================================
   // Channel sequencer
   ttc_pkg::ttc_chan_t ch_ff;
   ttc_pkg::ttc_line_t ln_ff;
   logic [14:0] cbuf_ff;
   logic [3:0]  ccnt_ff;
   logic        start_ln;
   logic        take_rdy;
   logic        ctl_wr;
   logic        ln_rest;
   logic [2:0]  sc;
   logic        is_chr;
   logic        is_ctl;
   logic        good;
   logic [7:0]  msg_dat;
   logic [7:0]  stat_byte;
   logic [2:0]  rc_line;
   logic [14:0] nxt_reply;

   assign ln_rest   = (ln_ff == ttc_pkg::LN_REST);
   assign sc        = cbuf_ff[2:0];
   assign msg_dat   = cbuf_ff[ttc_pkg::DAT_LSB +: 8];
   assign is_chr    = (sc == ttc_pkg::SC_NORMAL);
   assign is_ctl    = (sc == ttc_pkg::SC_MAINT);
   assign good      = (is_chr | is_ctl) &
                      (^cbuf_ff[ttc_pkg::RC_LSB-1:ttc_pkg::PAR_BIT]);
   assign stat_byte = {alarm, enable_ff};
   assign rc_line   = ln_rest ? ttc_pkg::RC_ACCEPT : ttc_pkg::RC_BUSY;

   // Decision table applied in the process state
   always_comb begin
      start_ln  = 1'b0;
      take_rdy  = 1'b0;
      ctl_wr    = 1'b0;
      nxt_reply = build_reply(ttc_pkg::SC_MAINT, stat_byte,
                              ttc_pkg::RC_BADPAR);
      if (ch_ff == ttc_pkg::CH_PROC && good) begin
         ctl_wr = is_ctl;
         if (rdy_ff) begin
            take_rdy  = 1'b1;
            nxt_reply = build_reply(ttc_pkg::SC_NORMAL, line_reg_ff,
                                    rc_line);
         end else begin
            start_ln  = is_chr & ln_rest;
            nxt_reply = build_reply(ttc_pkg::SC_MAINT, stat_byte,
                                    rc_line);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ch_ff   <= ttc_pkg::CH_RECV;
         cbuf_ff <= '0;
         ccnt_ff <= 4'h0;
      end else if (ce) begin
         unique case (ch_ff)
            ttc_pkg::CH_RECV: begin
               if (init_p) begin
                  cbuf_ff <= '0;
               end else if (cbuf_ff[0]) begin
                  ch_ff <= ttc_pkg::CH_PROC;
               end else if (shift_p) begin
                  cbuf_ff <= {dat_s, cbuf_ff[14:1]};
               end
            end
            ttc_pkg::CH_PROC: begin
               cbuf_ff <= nxt_reply;
               ccnt_ff <= 4'h0;
               ch_ff   <= ttc_pkg::CH_XMIT;
            end
            ttc_pkg::CH_XMIT: begin
               // Trailing zeros from the host pace the reply
               if (shift_p) begin
                  cbuf_ff <= {1'b0, cbuf_ff[14:1]};
                  ccnt_ff <= ccnt_ff + 4'h1;
                  if (ccnt_ff == ttc_pkg::REPLY_LAST) begin
                     ch_ff   <= ttc_pkg::CH_RECV;
                     cbuf_ff <= '0;
                  end
               end
            end
         endcase
      end
   end

   assign host_tx_data = cbuf_ff[0];
   assign host_tx_en   = (ch_ff == ttc_pkg::CH_XMIT);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_ff <= 4'h0;
         test_ff   <= 4'h0;
      end else if (ce && ctl_wr) begin
         enable_ff <= msg_dat[3:0];
         test_ff   <= msg_dat[7:4];
      end
   end

   // ==========================================================
   // Line timer: quarter-bit ticks, realigned at frame start
   logic [QW-1:0] qcnt_ff;
   logic          qtick;
   logic          restart;

   assign qtick = (qcnt_ff == '0);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         qcnt_ff <= QW'(QTR_CYC - 1);
      end else if (ce) begin
         if (restart || qtick) begin
            qcnt_ff <= QW'(QTR_CYC - 1);
         end else begin
            qcnt_ff <= qcnt_ff - QW'(1);
         end
      end
   end

   // ==========================================================
   // Line sequencer
   logic [7:0]  lbuf_ff;
   logic [5:0]  fcnt_ff;
   logic [5:0]  nxt_fcnt;
   logic        ln_done;
   logic [10:0] frame;

   assign nxt_fcnt = fcnt_ff + 6'h01;
   assign frame    = {2'b11, lbuf_ff, 1'b0};
   assign restart  = ln_rest & (start_ln | ~line_in);
   assign ln_done  = qtick & (nxt_fcnt == ttc_pkg::FRAME_QTRS) &
                     (ln_ff == ttc_pkg::LN_XMIT ||
                      ln_ff == ttc_pkg::LN_RECV);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ln_ff   <= ttc_pkg::LN_REST;
         lbuf_ff <= 8'h00;
         fcnt_ff <= 6'h00;
      end else if (ce) begin
         unique case (ln_ff)
            ttc_pkg::LN_REST: begin
               fcnt_ff <= 6'h00;
               if (start_ln) begin
                  lbuf_ff <= msg_dat;
                  ln_ff   <= ttc_pkg::LN_XMIT;
               end else if (!line_in) begin
                  ln_ff <= ttc_pkg::LN_HIT;
               end
            end
            ttc_pkg::LN_HIT: begin
               if (qtick) begin
                  fcnt_ff <= nxt_fcnt;
                  // Mark after a quarter bit means line noise
                  ln_ff   <= line_in ? ttc_pkg::LN_REST
                                     : ttc_pkg::LN_RECV;
               end
            end
            ttc_pkg::LN_RECV: begin
               if (qtick) begin
                  fcnt_ff <= nxt_fcnt;
                  if (nxt_fcnt[1:0] == 2'h2 &&
                      nxt_fcnt >= ttc_pkg::FIRST_SAMPLE &&
                      nxt_fcnt <= ttc_pkg::LAST_SAMPLE) begin
                     lbuf_ff <= {line_in, lbuf_ff[7:1]};
                  end
                  if (ln_done) begin
                     ln_ff <= ttc_pkg::LN_REST;
                  end
               end
            end
            ttc_pkg::LN_XMIT: begin
               if (qtick) begin
                  fcnt_ff <= nxt_fcnt;
                  if (ln_done) begin
                     ln_ff <= ttc_pkg::LN_REST;
                  end
               end
            end
         endcase
      end
   end

   // Idle ports hold mark; enabled ports share one frame
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tty_tx <= 4'hF;
      end else if (ce) begin
         for (int i = 0; i < 4; i++) begin
            tty_tx[i] <= (ln_ff == ttc_pkg::LN_XMIT && enable_ff[i])
                         ? frame[fcnt_ff[5:2]] : 1'b1;
         end
      end
   end

   // Received or sent character lands in the line register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         line_reg_ff <= 8'h00;
      end else if (ce && ln_done) begin
         line_reg_ff <= lbuf_ff;
      end
   end

   // A completion in the same cycle as a poll keeps the flag
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdy_ff <= 1'b0;
      end else if (ce) begin
         if (ln_done) begin
            rdy_ff <= 1'b1;
         end else if (take_rdy) begin
            rdy_ff <= 1'b0;
         end
      end
   end

   // Interrupt held until a host message reaches the process state or demand mode is switched off
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         demand_irq <= 1'b0;
      end else if (ce) begin
         if (ln_done && demand_ff) begin
            demand_irq <= 1'b1;
         end else if (ch_ff == ttc_pkg::CH_PROC || !demand_ff) begin
            demand_irq <= 1'b0;
         end
      end
   end

   // ==========================================================
   // AHB-Lite slave, zero wait states, always OKAY
   logic       ap_wr_ff;
   logic [3:0] ap_ofs_ff;
   logic       take;
   logic [3:0] ofs;
   logic [31:0] rd_mux;
   logic [31:0] rdata_ff;

   assign take = ahb_i.hsel & ahb_i.htrans[1] & hready;
   assign ofs  = ahb_i.haddr[3:0];

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (ahb_i.haddr[31:4] == 28'h0) begin
         unique case (ofs)
            ttc_pkg::OFS_CTRL: rd_mux = {31'h0, demand_ff};
            ttc_pkg::OFS_STAT: rd_mux = {16'h0000, ln_ff, ch_ff,
                                         rdy_ff, stat_byte};
            ttc_pkg::OFS_LINE: rd_mux = {24'h00_0000, line_reg_ff};
            default:           rd_mux = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ap_wr_ff     <= 1'b0;
         ap_ofs_ff    <= 4'h0;
         rdata_ff     <= 32'h0000_0000;
      end else if (ce) begin
         ap_wr_ff <= take & ahb_i.hwrite &
                     (ahb_i.haddr[31:4] == 28'h0);
         if (take) begin
            ap_ofs_ff <= ofs;
         end
         if (take && !ahb_i.hwrite) begin
            rdata_ff <= rd_mux;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         demand_ff <= ttc_pkg::CTRL_DEMAND_RST;
      end else if (ce && ap_wr_ff && ap_ofs_ff == ttc_pkg::OFS_CTRL) begin
         demand_ff <= ahb_i.hwdata[ttc_pkg::CTRL_DEMAND_BIT];
      end
   end

   // One driver for the whole response struct
   assign ahb_o = '{hrdata: rdata_ff, hreadyout: 1'b1, hresp: 1'b0};

endmodule : ttc_top

`default_nettype wire

//--- ttc_top_chk.sv
// Checker: port-level assertions for the teletype channel controller
`default_nettype none

module ttc_top_chk #(
   parameter int QTR_CYC = 8
) (
   input wire logic                  core_clk,
   input wire logic                  rst_n,
   input wire ttc_pkg::ttc_ahb_req_t ahb_i,
   input wire logic                  hready,
   input wire ttc_pkg::ttc_ahb_rsp_t ahb_o,
   input wire logic                  host_tx_en,
   input wire logic                  demand_irq,
   input wire logic [3:0]            tty_tx
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Low-run counters: space runs on ports 0 and 2 are whole bit periods
   logic [31:0] lo0_ff;
   logic [31:0] lo2_ff;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lo0_ff <= 32'h0;
         lo2_ff <= 32'h0;
      end else begin
         lo0_ff <= tty_tx[0] ? 32'h0 : lo0_ff + 32'h1;
         lo2_ff <= tty_tx[2] ? 32'h0 : lo2_ff + 32'h1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // ==========================================================
   // Properties
   property p_rst_idle;
      $rose(rst_n) |-> tty_tx == 4'hF && !host_tx_en && !demand_irq;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("Outputs not idle after reset");

   property p_bus_ok;
      ahb_o.hreadyout && !ahb_o.hresp;
   endproperty
   a_bus_ok: assert property (p_bus_ok)
      else $error("Bus slave stalled or erred");

   property p_rd_hold;
      !(ahb_i.hsel && ahb_i.htrans[1] && hready && !ahb_i.hwrite)
         |=> $stable(ahb_o.hrdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("Read data moved without a read");

   property p_txen_len;
      $rose(host_tx_en) |-> host_tx_en[*8] ##[1:900] !host_tx_en;
   endproperty
   a_txen_len: assert property (p_txen_len)
      else $error("Reply enable length wrong");

   property p_irq_mark;
      $rose(demand_irq) |-> tty_tx == 4'hF;
   endproperty
   a_irq_mark: assert property (p_irq_mark)
      else $error("Interrupt before last stop bit ended");

   property p_irq_hold;
      $rose(demand_irq) |=> demand_irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("Interrupt dropped at once");

   property p_run0;
      $rose(tty_tx[0]) |-> lo0_ff != 32'h0 && lo0_ff % (4 * QTR_CYC) == 0;
   endproperty
   a_run0: assert property (p_run0)
      else $error("Port 0 space run not whole bits");

   property p_run2;
      $rose(tty_tx[2]) |-> lo2_ff != 32'h0 && lo2_ff % (4 * QTR_CYC) == 0;
   endproperty
   a_run2: assert property (p_run2)
      else $error("Port 2 space run not whole bits");

   c_irq: cover property ($rose(demand_irq));
   c_reply: cover property ($fell(host_tx_en));
   c_frame: cover property ($rose(tty_tx[2]));

endmodule : ttc_top_chk

bind ttc_top ttc_top_chk #(.QTR_CYC(QTR_CYC)) u_chk (
   .core_clk   (core_clk),
   .rst_n      (rst_n),
   .ahb_i      (ahb_i),
   .hready     (hready),
   .ahb_o      (ahb_o),
   .host_tx_en (host_tx_en),
   .demand_irq (demand_irq),
   .tty_tx     (tty_tx)
);

`default_nettype wire

//--- ttc_host_model.sv
// Host-side partner: sends 15-bit messages, collects 15-bit replies
`default_nettype none

module ttc_host_model (
   input  wire logic core_clk,
   input  wire logic host_tx_data,
   input  wire logic host_tx_en,
   output var  logic host_rx_data,
   output var  logic host_shift_n,
   output var  logic host_init
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      host_rx_data = 1'b1;
      host_shift_n = 1'b1;
      host_init    = 1'b0;
   end

   // ==========================================================
   // Init pulse, 15 bits, then 15 zero strobes clock the reply
   task automatic xfer(input logic [14:0] m, output logic [14:0] r);
      int i;
      host_init <= 1'b1;
      repeat (3) @(posedge core_clk);
      host_init <= 1'b0;
      repeat (3) @(posedge core_clk);
      for (i = 0; i < 30; i++) begin
         host_rx_data <= (i < 15) ? m[i] : 1'b0;
         host_shift_n <= 1'b0;
         repeat (4) @(posedge core_clk);
         if (i >= 15) begin
            r[i-15] = host_tx_en ? host_tx_data : 1'bx;
         end
         host_shift_n <= 1'b1;
         repeat (4) @(posedge core_clk);
      end
      // Released line is driven high, its idle level
      host_rx_data <= 1'b1;
      repeat (8) @(posedge core_clk);
   endtask : xfer

endmodule : ttc_host_model

`default_nettype wire

//--- test_teletype_channel_controller.sv
// Self-checking testbench for the teletype channel controller
`default_nettype none

`define CHK(g, e) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
   end \
end

module test_teletype_channel_controller;
   timeunit 1ns;
   timeprecision 1ps;

   // Short quarter tick keeps a frame near 700 cycles
   localparam int QTR = 16;
   localparam int BIT = 4 * QTR;

   logic                  core_clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic [3:0]            tty_rx = 4'hF;
   logic [3:0]            tty_alarm = 4'h0;
   ttc_pkg::ttc_ahb_req_t req = '0;
   ttc_pkg::ttc_ahb_rsp_t rsp;
   logic                  h_rx, h_sh, h_in, h_td, h_te, irq;
   logic [3:0]            tty_tx;
   logic [14:0]           r;
   logic [31:0]           v;
   int                    fails = 0;
   int                    cmp_count = 0;

   always #10 core_clk = ~core_clk;

   ttc_top #(.QTR_CYC(QTR)) dut (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .ce           (1'b1),
      .ahb_i        (req),
      .hready       (rsp.hreadyout),
      .ahb_o        (rsp),
      .host_rx_data (h_rx),
      .host_shift_n (h_sh),
      .host_init    (h_in),
      .host_tx_data (h_td),
      .host_tx_en   (h_te),
      .demand_irq   (irq),
      .tty_rx       (tty_rx),
      .tty_alarm    (tty_alarm),
      .tty_tx       (tty_tx)
   );

   ttc_host_model host (
      .core_clk     (core_clk),
      .host_tx_data (h_td),
      .host_tx_en   (h_te),
      .host_rx_data (h_rx),
      .host_shift_n (h_sh),
      .host_init    (h_in)
   );

   // ==========================================================
   // Helpers
   function automatic logic [14:0] mk(logic [2:0] sc, logic [7:0] d,
                                      logic [2:0] rc);
      return {rc, d, ~^d, sc};
   endfunction : mk

   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] wd);
      @(posedge core_clk);
      req.hsel <= 1'b1;
      req.haddr <= {24'h0, a};
      req.htrans <= 2'h2;
      req.hwrite <= w;
      req.hsize <= 3'h2;
      do @(posedge core_clk); while (rsp.hreadyout !== 1'b1);
      req.hsel <= 1'b0;
      req.htrans <= 2'h0;
      req.hwdata <= wd;
      do @(posedge core_clk); while (rsp.hreadyout !== 1'b1);
      v = rsp.hrdata;
   endtask : bus

   task automatic wait_irq();
      for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(negedge core_clk);
   endtask : wait_irq

   task automatic poll(input logic [7:0] c);
      host.xfer(mk(ttc_pkg::SC_MAINT, 8'h05, 3'h0), r);
      `CHK(r, mk(ttc_pkg::SC_NORMAL, c, ttc_pkg::RC_ACCEPT))
   endtask : poll

   // Port 0 carries a, other selected ports carry b
   task automatic tty_send(input logic [3:0] m, input logic [7:0] a,
                           input logic [7:0] b);
      logic [10:0] fa;
      logic [10:0] fb;
      fa = {2'b11, a, 1'b0};
      fb = {2'b11, b, 1'b0};
      @(posedge core_clk);
      for (int j = 0; j < 11; j++) begin
         tty_rx <= ~m | {{3{fb[j]}}, fa[j]};
         repeat (BIT) @(posedge core_clk);
      end
   endtask : tty_send

   task automatic frame_chk(input logic [7:0] c);
      logic [10:0] f;
      f = {2'b11, c, 1'b0};
      for (int j = 0; j < 4000 && tty_tx[0] !== 1'b0; j++) begin
         @(negedge core_clk);
      end
      repeat (2 * QTR) @(negedge core_clk);
      for (int j = 0; j < 11; j++) begin
         `CHK(tty_tx, {1'b1, f[j], 1'b1, f[j]})
         repeat (BIT) @(negedge core_clk);
      end
   endtask : frame_chk

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      bus(8'h00, 1'b0, 32'h0);
      `CHK(v, 32'h1)
      bus(8'h04, 1'b1, 32'hFFFF);
      bus(8'h04, 1'b0, 32'h0);
      `CHK(v, 32'h1200)
      bus(8'h08, 1'b0, 32'h0);
      `CHK(v, 32'h0)
      bus(8'h0C, 1'b0, 32'h0);
      `CHK(v, 32'h0)
      bus(8'h00, 1'b1, 32'h0);
      bus(8'h00, 1'b0, 32'h0);
      `CHK(v, 32'h0)
      bus(8'h00, 1'b1, 32'h1);
      `CHK(tty_tx, 4'hF)
   endtask : t_reset

   task automatic t_ctrl();
      host.xfer(mk(ttc_pkg::SC_MAINT, 8'h05, 3'h0), r);
      `CHK(r, mk(ttc_pkg::SC_MAINT, 8'h00, ttc_pkg::RC_ACCEPT))
      bus(8'h04, 1'b0, 32'h0);
      `CHK(v[3:0], 4'h5)
      host.xfer(mk(ttc_pkg::SC_MAINT, 8'h0F, 3'h0) ^ 15'h0008, r);
      `CHK(r, mk(ttc_pkg::SC_MAINT, 8'h05, ttc_pkg::RC_BADPAR))
      bus(8'h04, 1'b0, 32'h0);
      `CHK(v[3:0], 4'h5)
   endtask : t_ctrl

   task automatic t_alarm();
      tty_alarm <= 4'h8;
      host.xfer(mk(ttc_pkg::SC_MAINT, 8'h15, 3'h0), r);
      `CHK(r, mk(ttc_pkg::SC_MAINT, 8'h85, ttc_pkg::RC_ACCEPT))
      bus(8'h04, 1'b0, 32'h0);
      `CHK(v[7:4], 4'h9)
      tty_alarm <= 4'h0;
      host.xfer(mk(ttc_pkg::SC_MAINT, 8'h05, 3'h0), r);
      `CHK(r, mk(ttc_pkg::SC_MAINT, 8'h15, ttc_pkg::RC_ACCEPT))
   endtask : t_alarm

   task automatic t_tx();
      logic [14:0] r2;
      fork
         begin
            host.xfer(mk(ttc_pkg::SC_NORMAL, 8'hC1, 3'h0), r);
            host.xfer(mk(ttc_pkg::SC_NORMAL, 8'h33, 3'h0), r2);
         end
         frame_chk(8'hC1);
      join
      `CHK(r, mk(ttc_pkg::SC_MAINT, 8'h05, ttc_pkg::RC_ACCEPT))
      `CHK(r2, mk(ttc_pkg::SC_MAINT, 8'h05, ttc_pkg::RC_BUSY))
      wait_irq();
      `CHK(irq, 1'b1)
      bus(8'h08, 1'b0, 32'h0);
      `CHK(v, 32'hC1)
      poll(8'hC1);
      `CHK(irq, 1'b0)
   endtask : t_tx

   task automatic t_rx();
      tty_send(4'h2, 8'h5A, 8'h5A);
      wait_irq();
      bus(8'h08, 1'b0, 32'h0);
      `CHK(v, 32'h5A)
      poll(8'h5A);
   endtask : t_rx

   task automatic t_hit();
      @(posedge core_clk);
      tty_rx <= 4'hB;
      repeat (3) @(posedge core_clk);
      tty_rx <= 4'hF;
      bus(8'h04, 1'b0, 32'h0);
      `CHK(v[15:8], 8'h42)
      repeat (3 * QTR) @(posedge core_clk);
      bus(8'h04, 1'b0, 32'h0);
      `CHK(v[15:8], 8'h12)
   endtask : t_hit

   task automatic t_collide();
      tty_send(4'h5, 8'h6C, 8'h3B);
      wait_irq();
      bus(8'h08, 1'b0, 32'h0);
      `CHK(v, 32'h28)
      poll(8'h28);
   endtask : t_collide

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      t_reset();
      t_ctrl();
      t_alarm();
      t_tx();
      t_rx();
      t_hit();
      t_collide();
      finish_test();
   end

   // Whole run needs about 4200 cycles
   initial begin
      repeat (30000) @(posedge core_clk);
      fails++;
      finish_test();
   end

endmodule : test_teletype_channel_controller

`default_nettype wire
